// ==== acg_regs.svh ====
// register map, field positions and counts of the audio clock generator
// Operation
// - ws period: 64 bit clocks, or 32
// - master to bit divide: 4, 2, 1, 8
// - cleaner reference: vco/8, /4, /2, oscillator
// - nonzero cleaning mode cleans clock before use
// - role bit drives bit clock, word select
// - nonzero cts and n synthesize audio clock
// - loop filter feedback divided by 2^shift
// - status bits 5:3 show cleaner input fill
// - status bits 2:0 show cleaner output fill
`ifndef ACG_REGS_SVH
`define ACG_REGS_SVH

`define ACG_IDX_CTRL      8'h30
`define ACG_IDX_CTS0      8'h31
`define ACG_IDX_CTS1      8'h32
`define ACG_IDX_CTS2      8'h33
`define ACG_IDX_N0        8'h34
`define ACG_IDX_N1        8'h35
`define ACG_IDX_N2_LOOP_FILTER_SHIFT  8'h36
`define ACG_IDX_STATUS    8'h37
`define ACG_ADDR_OF(idx)  ({22'h000000, (idx), 2'b00})

`define ACG_RST_BYTE      8'h00
`define ACG_CTRL_WS_RATIO 7
`define ACG_CTRL_MCLK_HI  6
`define ACG_CTRL_MCLK_LO  5
`define ACG_CTRL_REF_HI   4
`define ACG_CTRL_REF_LO   3
`define ACG_CTRL_CLEAN_HI 2
`define ACG_CTRL_CLEAN_LO 1
`define ACG_CTRL_ROLE     0
`define ACG_LOOP_FILTER_SHIFT_HI      7
`define ACG_LOOP_FILTER_SHIFT_LO      4
`define ACG_NHI_HI        3
`define ACG_NHI_LO        0
`define ACG_STS_IN_HI     5
`define ACG_STS_IN_LO     3
`define ACG_STS_OUT_HI    2
`define ACG_STS_OUT_LO    0

`define ACG_HALF_WS64     6'h20
`define ACG_HALF_WS32     6'h10
`define ACG_FILL_MAX      3'h7

`endif

// ==== acg_pkg.sv ====
// types shared by the audio clock generator modules
package acg_pkg;
	typedef logic [2:0] acg_fill_type;
	typedef enum logic [1:0] {
		ACG_MCLK_DIV4 = 2'h0,
		ACG_MCLK_DIV2 = 2'h1,
		ACG_MCLK_DIV1 = 2'h2,
		ACG_MCLK_DIV8 = 2'h3
	} acg_mclk_ratio_type;
	typedef enum logic [1:0] {
		ACG_REF_VCO8 = 2'h0,
		ACG_REF_VCO4 = 2'h1,
		ACG_REF_VCO2 = 2'h2,
		ACG_REF_OSC  = 2'h3
	} acg_ref_sel_type;
	typedef enum logic [1:0] {
		ACG_CLEAN_OFF = 2'h0,
		ACG_CLEAN_R1  = 2'h1,
		ACG_CLEAN_R2  = 2'h2,
		ACG_CLEAN_R4  = 2'h3
	} acg_clean_mode_type;
endpackage

// ==== acg_cleaner.sv ====
// digital clock cleaner with input and output token fifos
`include "acg_regs.svh"
module acg_cleaner
	import acg_pkg::*;
(
	input  wire logic               i_sys_clk,
	input  wire logic               i_resetn,
	input  wire acg_clean_mode_type i_mode,
	input  wire logic               i_in_tick,
	input  wire logic               i_ref_tick,
	input  wire logic [3:0]         i_shift,
	output logic                    o_clean_tick,
	output acg_fill_type            o_in_fill,
	output acg_fill_type            o_out_fill
);
	logic [2:0]   ratio;
	logic         pop;
	logic         drain;
	logic [3:0]   out_sum;
	logic [15:0]  lf_cnt;
	logic [15:0]  next_lf_cnt;
	acg_fill_type next_in_fill;
	acg_fill_type next_out_fill;
	logic         next_clean_tick;

	always_comb begin
		unique case (i_mode)
			ACG_CLEAN_R1: ratio = 3'h1;
			ACG_CLEAN_R2: ratio = 3'h2;
			ACG_CLEAN_R4: ratio = 3'h4;
			ACG_CLEAN_OFF: ratio = 3'h0;
		endcase
		out_sum = {1'b0, o_out_fill} + {1'b0, ratio};
		// a token moves only if the whole burst fits, so none is half delivered
		pop = i_ref_tick && (o_in_fill != 3'h0) && (out_sum <= {1'b0, `ACG_FILL_MAX});
		// feedback pacing: one drain per 2^shift reference ticks
		drain = i_ref_tick && (o_out_fill != 3'h0) && (lf_cnt >= ((16'h1 << i_shift) - 16'h1));
		next_lf_cnt = lf_cnt;
		if (drain) begin
			next_lf_cnt = 16'h0;
		end else if (i_ref_tick && (lf_cnt != 16'hffff)) begin
			next_lf_cnt = lf_cnt + 16'h1;
		end
		next_in_fill = o_in_fill;
		// a tick arriving while full is dropped unless a pop frees a slot that cycle; the loop absorbs the slip
		if (i_in_tick && !pop && (o_in_fill != `ACG_FILL_MAX)) begin
			next_in_fill = o_in_fill + 3'h1;
		end else if (!i_in_tick && pop) begin
			next_in_fill = o_in_fill - 3'h1;
		end
		next_out_fill = o_out_fill;
		if (pop) begin
			next_out_fill = 3'((pop ? out_sum : {1'b0, o_out_fill}) - {3'h0, drain});
		end else if (drain) begin
			next_out_fill = o_out_fill - 3'h1;
		end
		next_clean_tick = drain;
		if (i_mode == ACG_CLEAN_OFF) begin
			next_in_fill = 3'h0;
			next_out_fill = 3'h0;
			next_lf_cnt = 16'h0;
			next_clean_tick = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			lf_cnt <= 16'h0;
			o_in_fill <= 3'h0;
			o_out_fill <= 3'h0;
			o_clean_tick <= 1'b0;
		end else begin
			lf_cnt <= next_lf_cnt;
			o_in_fill <= next_in_fill;
			o_out_fill <= next_out_fill;
			o_clean_tick <= next_clean_tick;
		end
	end

	a_clean_off_empty : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		i_mode == ACG_CLEAN_OFF |=> o_in_fill == 3'h0 && o_out_fill == 3'h0 && !o_clean_tick)
		else $error("cleaner not emptied while off");
	a_in_fill_step : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		i_mode != ACG_CLEAN_OFF && $past(i_mode) != ACG_CLEAN_OFF && i_in_tick && !pop
		&& o_in_fill != `ACG_FILL_MAX |=> o_in_fill == $past(o_in_fill) + 3'h1)
		else $error("input fill did not follow a tick");
	a_drain_paced : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		o_clean_tick && i_shift == 4'h3 && $past(i_shift) == 4'h3 |-> $past(lf_cnt) >= 16'h7)
		else $error("cleaned tick ahead of loop filter");
endmodule

// ==== acg_audio_clock_gen.sv ====
// audio clock generation and cleaning with an ahb-lite register slave
//
// The implementer's own choice: register access over AHB-Lite.
`include "acg_regs.svh"
module acg_audio_clock_gen
	import acg_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	input  wire logic        i_serial_link_vco_clock,
	input  wire logic        i_always_on_oscillator,
	input  wire logic        i_bit_clk,
	input  wire logic        i_word_select_pin,
	output logic [31:0]      o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	output logic             o_bit_clk,
	output logic             o_bit_clk_oe,
	output logic             o_word_select_pin,
	output logic             o_word_select_pin_oe,
	output logic             o_audio_mclk,
	output logic             o_word_select_rx
);
	function automatic logic addr_hit(input logic [31:0] a);
		logic [31:0] base;
		base = `ACG_ADDR_OF(`ACG_IDX_CTRL);
		return (a[31:5] == base[31:5]) && (a[1:0] == 2'h0);
	endfunction
	function automatic logic [7:0] addr_index(input logic [31:0] a);
		return `ACG_IDX_CTRL + {5'h00, a[4:2]};
	endfunction
	// register file and bus slave
	logic [7:0]   audio_clock_control;
	logic [23:0]  audio_cts;
	logic [19:0]  audio_n;
	logic [3:0]   loop_filter_shift_value;
	logic         wr_pend;
	logic [7:0]   wr_index;
	logic [7:0]   next_audio_clock_control;
	logic [23:0]  next_audio_cts;
	logic [19:0]  next_audio_n;
	logic [3:0]   next_loop_filter_shift_value;
	logic         next_wr_pend;
	logic [7:0]   next_wr_index;
	logic [31:0]  next_hrdata;
	logic         take;
	logic [7:0]   rd_index;
	logic [7:0]   wbyte;
	acg_fill_type cleaner_in_fill;
	acg_fill_type cleaner_out_fill;
	always_comb begin
		take = i_hsel && i_hready && i_htrans[1];
		rd_index = addr_index(i_haddr);
		wbyte = i_hwdata[7:0];
		next_audio_clock_control = audio_clock_control;
		next_audio_cts = audio_cts;
		next_audio_n = audio_n;
		next_loop_filter_shift_value = loop_filter_shift_value;
		next_wr_pend = take && i_hwrite && addr_hit(i_haddr);
		next_wr_index = take ? rd_index : wr_index;
		next_hrdata = o_hrdata;
		if (wr_pend) begin
			unique case (wr_index)
				`ACG_IDX_CTRL: next_audio_clock_control = wbyte;
				`ACG_IDX_CTS0: next_audio_cts[7:0] = wbyte;
				`ACG_IDX_CTS1: next_audio_cts[15:8] = wbyte;
				`ACG_IDX_CTS2: next_audio_cts[23:16] = wbyte;
				`ACG_IDX_N0: next_audio_n[7:0] = wbyte;
				`ACG_IDX_N1: next_audio_n[15:8] = wbyte;
				`ACG_IDX_N2_LOOP_FILTER_SHIFT: begin
					next_audio_n[19:16] = wbyte[`ACG_NHI_HI:`ACG_NHI_LO];
					next_loop_filter_shift_value = wbyte[`ACG_LOOP_FILTER_SHIFT_HI:`ACG_LOOP_FILTER_SHIFT_LO];
				end
				default: begin
				end
			endcase
		end
		if (take && !i_hwrite) begin
			next_hrdata = 32'h0;
			if (addr_hit(i_haddr)) begin
				unique case (rd_index)
					`ACG_IDX_CTRL: next_hrdata[7:0] = audio_clock_control;
					`ACG_IDX_CTS0: next_hrdata[7:0] = audio_cts[7:0];
					`ACG_IDX_CTS1: next_hrdata[7:0] = audio_cts[15:8];
					`ACG_IDX_CTS2: next_hrdata[7:0] = audio_cts[23:16];
					`ACG_IDX_N0: next_hrdata[7:0] = audio_n[7:0];
					`ACG_IDX_N1: next_hrdata[7:0] = audio_n[15:8];
					`ACG_IDX_N2_LOOP_FILTER_SHIFT: next_hrdata[7:0] = {loop_filter_shift_value, audio_n[19:16]};
					// live levels, nothing is cleared by the read
					`ACG_IDX_STATUS: next_hrdata[7:0] = {2'h0, cleaner_in_fill, cleaner_out_fill};
					default: next_hrdata = 32'h0;
				endcase
			end
		end
	end
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			audio_clock_control <= `ACG_RST_BYTE;
			audio_cts <= 24'h0;
			audio_n <= 20'h0;
			loop_filter_shift_value <= 4'h0;
			wr_pend <= 1'b0;
			wr_index <= 8'h0;
			o_hrdata <= 32'h0;
			o_hreadyout <= 1'b0;
			o_hresp <= 1'b0;
		end else begin
			audio_clock_control <= next_audio_clock_control;
			audio_cts <= next_audio_cts;
			audio_n <= next_audio_n;
			loop_filter_shift_value <= next_loop_filter_shift_value;
			wr_pend <= next_wr_pend;
			wr_index <= next_wr_index;
			o_hrdata <= next_hrdata;
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end
	end
	// control fields
	logic               bitclk_per_word_sel;
	acg_mclk_ratio_type mclk_ratio;
	acg_ref_sel_type    ref_sel;
	acg_clean_mode_type clean_mode;
	logic               drive_role;
	assign bitclk_per_word_sel = audio_clock_control[`ACG_CTRL_WS_RATIO];
	assign mclk_ratio = acg_mclk_ratio_type'(audio_clock_control[`ACG_CTRL_MCLK_HI:`ACG_CTRL_MCLK_LO]);
	assign ref_sel = acg_ref_sel_type'(audio_clock_control[`ACG_CTRL_REF_HI:`ACG_CTRL_REF_LO]);
	assign clean_mode = acg_clean_mode_type'(audio_clock_control[`ACG_CTRL_CLEAN_HI:`ACG_CTRL_CLEAN_LO]);
	assign drive_role = audio_clock_control[`ACG_CTRL_ROLE];
	// pin synchronisers: vco, oscillator, bit clock, word select
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic [3:0] sync3;
	logic [3:0] pin_level;
	logic [3:0] pin_rise;
	logic [3:0] next_pin_level;
	logic [3:0] next_pin_rise;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			// a change counts only once the two later stages agree
			next_pin_level[i] = (sync2[i] == sync3[i]) ? sync3[i] : pin_level[i];
			next_pin_rise[i] = next_pin_level[i] && !pin_level[i];
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
			sync3 <= 4'h0;
			pin_level <= 4'h0;
			pin_rise <= 4'h0;
		end else begin
			sync1 <= {i_word_select_pin, i_bit_clk, i_always_on_oscillator,
				i_serial_link_vco_clock};
			sync2 <= sync1;
			sync3 <= sync2;
			pin_level <= next_pin_level;
			pin_rise <= next_pin_rise;
		end
	end
	// cleaner reference divider and n/cts synthesis
	logic [2:0]  vco_cnt;
	logic        ref_tick;
	logic [24:0] synth_acc;
	logic        synth_tick;
	logic [2:0]  next_vco_cnt;
	logic        next_ref_tick;
	logic [24:0] next_synth_acc;
	logic [24:0] synth_sum;
	logic        next_synth_tick;
	always_comb begin
		next_vco_cnt = pin_rise[0] ? vco_cnt + 3'h1 : vco_cnt;
		unique case (ref_sel)
			ACG_REF_VCO8: next_ref_tick = pin_rise[0] && (vco_cnt[2:0] == 3'h7);
			ACG_REF_VCO4: next_ref_tick = pin_rise[0] && (vco_cnt[1:0] == 2'h3);
			ACG_REF_VCO2: next_ref_tick = pin_rise[0] && vco_cnt[0];
			ACG_REF_OSC: next_ref_tick = pin_rise[1];
		endcase
		// fractional divide: one tick per cts/n system cycles on average
		synth_sum = synth_acc + {5'h00, audio_n};
		next_synth_tick = 1'b0;
		next_synth_acc = 25'h0;
		if (audio_cts != 24'h0 && audio_n != 20'h0) begin
			if (synth_sum >= {1'b0, audio_cts}) begin
				next_synth_acc = synth_sum - {1'b0, audio_cts};
				next_synth_tick = 1'b1;
			end else begin
				next_synth_acc = synth_sum;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			vco_cnt <= 3'h0;
			ref_tick <= 1'b0;
			synth_acc <= 25'h0;
			synth_tick <= 1'b0;
		end else begin
			vco_cnt <= next_vco_cnt;
			ref_tick <= next_ref_tick;
			synth_acc <= next_synth_acc;
			synth_tick <= next_synth_tick;
		end
	end
	logic clean_in_tick;
	logic clean_tick;

	// incoming bit clock is cleaned when received, synthesized clock when driving
	assign clean_in_tick = drive_role ? synth_tick : pin_rise[2];
	acg_cleaner u_cleaner (
		.i_sys_clk    (i_sys_clk),
		.i_resetn     (i_resetn),
		.i_mode       (clean_mode),
		.i_in_tick    (clean_in_tick),
		.i_ref_tick   (ref_tick),
		.i_shift      (loop_filter_shift_value),
		.o_clean_tick (clean_tick),
		.o_in_fill    (cleaner_in_fill),
		.o_out_fill   (cleaner_out_fill)
	);
	// clock generation: master clock edges, bit clock, word select
	logic       mclk_tick;
	logic [2:0] div_cnt;
	logic [2:0] div_last;
	logic [5:0] bit_cnt;
	logic [5:0] half_ws;
	logic [2:0] next_div_cnt;
	logic [5:0] next_bit_cnt;
	logic       next_bit_clk;
	logic       next_ws;
	logic       next_mclk;
	always_comb begin
		mclk_tick = (clean_mode != ACG_CLEAN_OFF) ? clean_tick : (drive_role && synth_tick);
		unique case (mclk_ratio)
			ACG_MCLK_DIV4: div_last = 3'h3;
			ACG_MCLK_DIV2: div_last = 3'h1;
			ACG_MCLK_DIV1: div_last = 3'h0;
			ACG_MCLK_DIV8: div_last = 3'h7;
		endcase
		half_ws = bitclk_per_word_sel ? `ACG_HALF_WS32 : `ACG_HALF_WS64;
		next_mclk = mclk_tick ? !o_audio_mclk : o_audio_mclk;
		next_div_cnt = div_cnt;
		next_bit_cnt = bit_cnt;
		next_bit_clk = o_bit_clk;
		next_ws = o_word_select_pin;
		if (!drive_role) begin
			next_div_cnt = 3'h0;
			next_bit_cnt = 6'h0;
			next_bit_clk = 1'b0;
			next_ws = 1'b0;
		end else if (mclk_tick) begin
			if (div_cnt >= div_last) begin
				next_div_cnt = 3'h0;
				next_bit_clk = !o_bit_clk;
				// word select moves on the falling bit clock edge
				if (o_bit_clk) begin
					if (bit_cnt >= half_ws - 6'h1) begin
						next_bit_cnt = 6'h0;
						next_ws = !o_word_select_pin;
					end else begin
						next_bit_cnt = bit_cnt + 6'h1;
					end
				end
			end else begin
				next_div_cnt = div_cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			div_cnt <= 3'h0;
			bit_cnt <= 6'h0;
			o_bit_clk <= 1'b0;
			o_word_select_pin <= 1'b0;
			o_bit_clk_oe <= 1'b0;
			o_word_select_pin_oe <= 1'b0;
			o_audio_mclk <= 1'b0;
			o_word_select_rx <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			bit_cnt <= next_bit_cnt;
			o_bit_clk <= next_bit_clk;
			o_word_select_pin <= next_ws;
			o_bit_clk_oe <= drive_role;
			o_word_select_pin_oe <= drive_role;
			o_audio_mclk <= next_mclk;
			o_word_select_rx <= pin_level[3];
		end
	end
	// helper: bit clock periods seen since the last word select change
	logic [6:0] chk_bits;
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			chk_bits <= 7'h0;
		end else if (next_audio_clock_control != audio_clock_control) begin
			chk_bits <= 7'h7f; // a half period begun under old settings is not judged
		end else if (o_word_select_pin != next_ws || !drive_role) begin
			chk_bits <= 7'h0;
		end else if (o_bit_clk && !next_bit_clk && chk_bits != 7'h7f) begin
			chk_bits <= chk_bits + 7'h1;
		end
	end
	a_ws_half_len : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		drive_role && $stable(audio_clock_control) && o_word_select_pin != next_ws
		&& next_bit_cnt == 6'h0 && chk_bits != 7'h7f |-> chk_bits + 7'h1 == {1'b0, half_ws})
		else $error("word select half period wrong length");
	a_bclk_on_mclk : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		$past(drive_role) && $changed(o_bit_clk) |-> $past(mclk_tick) && $past(div_cnt >= div_last))
		else $error("bit clock moved off the master clock divide");
	a_osc_ref : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		ref_sel == ACG_REF_OSC && $stable(ref_sel) |-> ref_tick == $past(pin_rise[1]))
		else $error("oscillator reference not followed");
	a_mclk_bypass : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		clean_mode == ACG_CLEAN_OFF && drive_role && synth_tick |=> $changed(o_audio_mclk))
		else $error("uncleaned master clock edge missing");
	a_pins_input : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		!drive_role ##1 !drive_role |-> !o_bit_clk_oe && !o_word_select_pin_oe && !o_bit_clk)
		else $error("pins driven in receive role");
	a_synth_idle : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		audio_cts == 24'h0 || audio_n == 20'h0 |=> !synth_tick)
		else $error("audio clock synthesized from zero value");
	a_status_read : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		take && !i_hwrite && i_haddr == `ACG_ADDR_OF(`ACG_IDX_STATUS)
		|=> o_hrdata == {26'h0, $past(cleaner_in_fill), $past(cleaner_out_fill)})
		else $error("status read shows wrong fill levels");
	a_write_lands : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		take && i_hwrite && i_haddr == `ACG_ADDR_OF(`ACG_IDX_N2_LOOP_FILTER_SHIFT)
		##1 1'b1 |=> loop_filter_shift_value == $past(i_hwdata[7:4]))
		else $error("loop filter shift not written");
endmodule

// ==== acg_audio_partner.sv ====
// external serial audio source and receiver facing the bit clock and word select pins
module acg_audio_partner (
	input  wire logic i_src_en,
	input  wire logic i_bclk_wire,
	input  wire logic i_ws_wire,
	output logic      o_src_bclk,
	output logic      o_src_ws,
	output int        o_bclk_per_ws
);
	timeunit 1ns;
	timeprecision 1ps;
	int rises;
	int bits;
	// source side: 80 ns bit clock, word select flips on a falling edge every 32 bits
	initial begin
		o_src_bclk = 1'b0;
		o_src_ws = 1'b0;
		bits = 0;
		forever begin
			#40;
			// clock stands still while the device owns the pins
			if (i_src_en) begin
				o_src_bclk = ~o_src_bclk;
				if (!o_src_bclk) begin
					bits++;
					if (bits == 32) begin
						o_src_ws = ~o_src_ws;
						bits = 0;
					end
				end
			end else begin
				o_src_bclk = 1'b0;
			end
		end
	end
	// receiver side: bit clock rises counted over one full word select period
	initial begin
		rises = 0;
		o_bclk_per_ws = 0;
	end
	always @(posedge i_bclk_wire) begin
		rises++;
	end
	always @(posedge i_ws_wire) begin
		o_bclk_per_ws = rises;
		rises = 0;
	end
endmodule

// ==== testbench.sv ====
// self-checking bench for the audio clock generator
`include "acg_regs.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rstn, hsel, hwrite, hready, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic        vco, osc, vco_run, osc_run, src_en;
	logic        bclk, bclk_oe, ws, ws_oe, mclk, ws_rx;
	logic        src_bclk, src_ws, bclk_wire, ws_wire, mclk_q, bclk_q;
	int          per_ws, tog, tog_per_bclk, tog_total;
	int          miscompares, comparisons;

	assign bclk_wire = bclk_oe ? bclk : src_bclk;
	assign ws_wire   = ws_oe ? ws : src_ws;

	acg_audio_clock_gen dut (
		.i_sys_clk(clk), .i_resetn(rstn), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(hready), .i_serial_link_vco_clock(vco), .i_always_on_oscillator(osc),
		.i_bit_clk(bclk_wire), .i_word_select_pin(ws_wire), .o_hrdata(hrdata),
		.o_hreadyout(hready), .o_hresp(hresp), .o_bit_clk(bclk), .o_bit_clk_oe(bclk_oe),
		.o_word_select_pin(ws), .o_word_select_pin_oe(ws_oe), .o_audio_mclk(mclk),
		.o_word_select_rx(ws_rx)
	);
	acg_audio_partner partner (
		.i_src_en(src_en), .i_bclk_wire(bclk_wire), .i_ws_wire(ws_wire),
		.o_src_bclk(src_bclk), .o_src_ws(src_ws), .o_bclk_per_ws(per_ws)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		vco = 1'b0;
		forever begin
			#20;
			if (vco_run) vco = ~vco;
		end
	end
	initial begin
		osc = 1'b0;
		forever begin
			#24;
			if (osc_run) osc = ~osc;
		end
	end
	// outputs are sampled mid-cycle so no edge race decides a count
	always @(negedge clk) begin
		if (mclk !== mclk_q) begin
			tog++;
			tog_total++;
		end
		if (bclk === 1'b1 && bclk_q === 1'b0) begin
			tog_per_bclk = tog;
			tog = 0;
		end
		mclk_q = mclk;
		bclk_q = bclk;
	end

	task automatic conclude();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_count(input string what, input int exp, input int got);
		comparisons++;
		if (got != exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
	endtask
	// hready is looked at mid-cycle, then the edge that samples it is passed
	task automatic wait_ready();
		logic ok;
		ok = 1'b0;
		for (int n = 0; n < 50 && !ok; n++) begin
			@(negedge clk);
			ok = (hready === 1'b1);
			@(posedge clk);
		end
		if (!ok) begin
			miscompares++;
			$display("CHECK FAILED hready expected 1 seen 0");
			conclude();
		end
	endtask
	task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= addr;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wdata;
		wait_ready();
		rdata = hrdata;
	endtask
	task automatic wr(input logic [31:0] addr, input logic [31:0] data);
		logic [31:0] d;
		ahb(1'b1, addr, data, d);
	endtask
	task automatic rd_check(input string what, input logic [31:0] addr, input logic [31:0] exp);
		logic [31:0] d;
		ahb(1'b0, addr, 32'h0, d);
		check_word(what, exp, d);
	endtask

	task automatic sc_reset();
		logic [7:0] idx;
		for (int i = 0; i < 8; i++) begin
			idx = `ACG_IDX_CTRL + 8'(i);
			rd_check("reset value", `ACG_ADDR_OF(idx), 32'h0);
		end
		check_word("hresp", 32'(hresp), 32'h0);
	endtask
	task automatic sc_regs();
		logic [7:0] idx;
		for (int i = 0; i < 7; i++) begin
			idx = `ACG_IDX_CTRL + 8'(i);
			wr(`ACG_ADDR_OF(idx), {24'hffffff, 8'h11 * 8'(i + 1)});
		end
		for (int i = 0; i < 7; i++) begin
			idx = `ACG_IDX_CTRL + 8'(i);
			rd_check("rw register", `ACG_ADDR_OF(idx), {24'h0, 8'h11 * 8'(i + 1)});
		end
		wr(`ACG_ADDR_OF(`ACG_IDX_STATUS), 32'hff);
		rd_check("status write ignored", `ACG_ADDR_OF(`ACG_IDX_STATUS), 32'h0);
		wr(32'h000000e0, 32'h5a);
		rd_check("unmapped", 32'h000000e0, 32'h0);
		rd_check("misaligned", 32'h000000c1, 32'h0);
		for (int i = 0; i < 7; i++) begin
			idx = `ACG_IDX_CTRL + 8'(i);
			wr(`ACG_ADDR_OF(idx), 32'h0);
		end
	endtask
	// device drives the pins from the synthesized clock, every divide and both ratios
	task automatic sc_gen();
		logic [7:0] ctl [5] = '{8'h01, 8'h21, 8'h41, 8'h61, 8'hc1};
		int         tg [5]  = '{8, 4, 2, 16, 2};
		int         wsn [5] = '{64, 64, 64, 64, 32};
		int         base;
		wr(`ACG_ADDR_OF(`ACG_IDX_CTS0), 32'h2);
		wr(`ACG_ADDR_OF(`ACG_IDX_N0), 32'h1);
		for (int i = 0; i < 5; i++) begin
			wr(`ACG_ADDR_OF(`ACG_IDX_CTRL), {24'h0, ctl[i]});
			cycles(4500);
			check_word("bit clock enable", 32'(bclk_oe), 32'h1);
			check_word("word select enable", 32'(ws_oe), 32'h1);
			check_count("mclk toggles per bit clock", tg[i], tog_per_bclk);
			check_count("bit clocks per word select", wsn[i], per_ws);
		end
		wr(`ACG_ADDR_OF(`ACG_IDX_CTS0), 32'h0);
		cycles(20);
		base = tog_total;
		cycles(200);
		check_count("mclk toggles with zero cts", base, tog_total);
	endtask
	// partner drives the pins; cleaner fills checked per reference source
	task automatic sc_recv();
		logic [1:0] rs [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h0};
		logic       vr [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
		logic [7:0] st [6] = '{8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h38, 8'h38};
		int         base;
		logic       was;
		src_en <= 1'b1;
		wr(`ACG_ADDR_OF(`ACG_IDX_CTRL), 32'h0);
		cycles(2);
		check_word("bit clock enable", 32'(bclk_oe), 32'h0);
		check_word("word select enable", 32'(ws_oe), 32'h0);
		check_word("bit clock out", 32'(bclk), 32'h0);
		base = tog_total;
		cycles(200);
		check_count("mclk toggles, cleaner off", base, tog_total);
		// a shift of 15 keeps the output tokens from draining in this run
		wr(`ACG_ADDR_OF(`ACG_IDX_N2_LOOP_FILTER_SHIFT), 32'hf0);
		for (int i = 0; i < 6; i++) begin
			// references switch while the cleaner is off, so a late edge is flushed
			vco_run <= vr[i];
			osc_run <= !vr[i];
			wr(`ACG_ADDR_OF(`ACG_IDX_CTRL), 32'h0);
			cycles(20);
			rd_check("status after mode off", `ACG_ADDR_OF(`ACG_IDX_STATUS), 32'h0);
			wr(`ACG_ADDR_OF(`ACG_IDX_CTRL), {27'h0, rs[i], 2'b01, 1'b0});
			cycles(2500);
			rd_check("cleaner fills", `ACG_ADDR_OF(`ACG_IDX_STATUS), {24'h0, st[i]});
			rd_check("fills reread", `ACG_ADDR_OF(`ACG_IDX_STATUS), {24'h0, st[i]});
		end
		// a shift of 3 lets one output token drain per eight reference ticks
		wr(`ACG_ADDR_OF(`ACG_IDX_N2_LOOP_FILTER_SHIFT), 32'h30);
		for (int m = 1; m < 4; m++) begin
			wr(`ACG_ADDR_OF(`ACG_IDX_CTRL), {27'h0, 2'h3, 2'(m), 1'b0});
			cycles(50);
			base = tog_total;
			cycles(500);
			check_count("mclk active when cleaning", 1, int'(tog_total > base));
		end
		// received word select follows the partner once its new level has settled
		was = src_ws;
		for (int n = 0; n < 1000 && src_ws === was; n++) begin
			@(posedge clk);
		end
		cycles(10);
		check_word("word select received", 32'(!was), 32'(ws_rx));
	endtask

	initial begin
		#800000;
		miscompares++;
		$display("CHECK FAILED watchdog expected end seen hang");
		conclude();
	end
	initial begin
		rstn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		vco_run = 1'b0;
		osc_run = 1'b0;
		src_en = 1'b0;
		tog = 0;
		tog_per_bclk = 0;
		tog_total = 0;
		miscompares = 0;
		comparisons = 0;
		repeat (11) @(posedge clk);
		check_word("hreadyout in reset", 32'(hready), 32'h0);
		@(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		sc_reset();
		sc_regs();
		sc_gen();
		sc_recv();
		conclude();
	end
endmodule
